// >>> inc/mtc_pkg.sv
// Register map, field positions and reset values of the translation controls
package mtc_pkg;
  localparam logic [3:0] REG_USER_ROOT = 4'h0;
  localparam logic [3:0] REG_SUPER_ROOT = 4'h1;
  localparam logic [3:0] REG_CONTROL = 4'h2;
  localparam logic [3:0] REG_DWIN0 = 4'h3;
  localparam logic [3:0] REG_DWIN1 = 4'h4;
  localparam logic [3:0] REG_IWIN0 = 4'h5;
  localparam logic [3:0] REG_IWIN1 = 4'h6;
  localparam logic [3:0] REG_PROBE = 4'h7;
  localparam logic [3:0] REG_PROBE_CMD = 4'h8;
  localparam logic [3:0] REG_PROBE_ADDR = 4'h9;

  localparam int CTL_ENABLE_BIT = 15;
  localparam int CTL_PAGE_BIT = 14;
  localparam logic [15:0] CTL_MASK = 16'hC000;
  localparam logic [31:0] ROOT_MASK = 32'hFFFFFE00;
  localparam logic [31:0] WIN_MASK = 32'hFFFFE364;

  localparam int WIN_BASE_LSB = 24;
  localparam int WIN_MASK_LSB = 16;
  localparam int WIN_EN_BIT = 15;
  localparam int WIN_PRIV_LSB = 13;
  localparam int WIN_U1_BIT = 9;
  localparam int WIN_U0_BIT = 8;
  localparam int WIN_CM_LSB = 5;
  localparam int WIN_WP_BIT = 2;

  localparam int PR_BUS_ERR = 11;
  localparam int PR_GLOBAL = 10;
  localparam int PR_U1 = 9;
  localparam int PR_U0 = 8;
  localparam int PR_SUPER = 7;
  localparam int PR_CM_LSB = 5;
  localparam int PR_MOD = 4;
  localparam int PR_WP = 2;
  localparam int PR_HIT = 1;
  localparam int PR_RES = 0;

  localparam logic [1:0] CM_WRITE_THROUGH = 2'h0;
  localparam logic [1:0] CM_COPYBACK = 2'h1;
  localparam logic [1:0] CM_SERIAL = 2'h2;
  localparam logic [1:0] CM_NONCACHE = 2'h3;

  localparam logic [31:0] WORD_RESET = 32'h00000000;
  localparam logic [15:0] CTL_RESET = 16'h0000;
endpackage

// >>> logic/mtc_regs.sv
// Translation control registers, transparent windows and probe result
//
// Behaviour
// - Supervisor accesses use supervisor root, user accesses use user root; while probe_start is high, table_root takes the probe's root.
// - Control bit 15 enables paging; reset clears it.
// - Paging off: physical address equals logical address.
// - Paging off, no window: write-through, unprotected, attribute outputs low.
// - Control bit 14 selects 4K or 8K page; reset keeps it.
// - Control writes and reset never invalidate translation cache.
// - Unimplemented control bits read zero; software writes zeros.
// - Windows work regardless of paging enable and inhibit pin.
// - Window bits 12-10, 7, 4, 3, 1, 0 read zero.
// - Window base compared with address 31-24; mask bits exclude base bits.
// - Window enable bit turns its block on or off.
// - Privilege field: 00 user, 01 supervisor, 1X either.
// - Matching window's user bits drive attribute outputs on bus transfers.
// - Cache mode: 00 write-through, 01 copyback, 10 serialized, 11 noncachable.
// - Window write protect aborts writes and read-modify-writes.
// - Probe result holds 20-bit physical field; bit 12 undefined for 8K.
// - Probe bus error sets bit 11 and clears all else.
// - Probe copies global, user, supervisor, modified, cache mode from page.
// - Probe write protect set if any visited descriptor protects.
// - Probe window hit sets hit and resident, clears the rest.
// - Resident set on window hit or valid page descriptor.
// - Translation inhibit pin suppresses paged translation.
//
// The placing of the registers and the plain strobed port were left to the implementer.
`timescale 1ns/100ps
module mtc_regs
  import mtc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic translation_inhibit_pin,
  input wire logic acc_valid,
  input wire logic [31:0] acc_addr,
  input wire logic privilege_space_bit,
  input wire logic acc_fetch,
  input wire logic acc_write,
  input wire logic acc_ext,
  input wire logic page_hit,
  input wire logic [31:0] page_phys,
  input wire logic [1:0] page_cache_mode,
  input wire logic [1:0] page_attr,
  input wire logic page_wp,
  output logic acc_done,
  output logic [31:0] phys_addr,
  output logic [1:0] cache_mode,
  output logic acc_abort,
  output logic page_attr_out_0,
  output logic page_attr_out_1,
  output logic translate_req,
  output logic [31:0] table_root,
  output logic page_8k,
  output logic probe_start,
  output logic [31:0] probe_addr,
  input wire logic probe_done,
  input wire logic probe_bus_err,
  input wire logic probe_valid,
  input wire logic [19:0] probe_phys,
  input wire logic probe_global,
  input wire logic [1:0] probe_attr,
  input wire logic probe_super,
  input wire logic [1:0] probe_cm,
  input wire logic probe_mod,
  input wire logic probe_wp_any
);
  logic [31:0] user_table_root_q;
  logic [31:0] supervisor_table_root_q;
  logic ctl_enable_q;
  logic ctl_page_q;
  logic [15:0] translation_control;
  logic [31:0] win_q [4];
  logic [31:0] probe_result_q;
  logic [31:0] probe_addr_q;
  logic probe_priv_q;
  logic probe_fetch_q;
  logic [2:0] inh_sync_q;
  logic inh_q;

  // Inhibit pin filter: accept a change once stages two and three agree
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      inh_sync_q <= 3'h0;
      inh_q <= 1'b0;
    end else begin
      inh_sync_q <= {inh_sync_q[1:0], translation_inhibit_pin};
      if (inh_sync_q[2] == inh_sync_q[1]) begin
        inh_q <= inh_sync_q[2];
      end
    end
  end

  wire wr_user = reg_wr && (reg_addr == REG_USER_ROOT);
  wire wr_super = reg_wr && (reg_addr == REG_SUPER_ROOT);
  wire wr_ctl = reg_wr && (reg_addr == REG_CONTROL);
  wire wr_pcmd = reg_wr && (reg_addr == REG_PROBE_CMD);
  wire wr_paddr = reg_wr && (reg_addr == REG_PROBE_ADDR);
  wire wr_probe = reg_wr && (reg_addr == REG_PROBE);

  // Translation cache is outside; no flush is issued from here
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      user_table_root_q <= WORD_RESET;
      supervisor_table_root_q <= WORD_RESET;
      ctl_enable_q <= 1'b0;
      probe_addr_q <= WORD_RESET;
      probe_priv_q <= 1'b0;
      probe_fetch_q <= 1'b0;
    end else begin
      if (wr_user) begin
        user_table_root_q <= reg_wdata & ROOT_MASK;
      end
      if (wr_super) begin
        supervisor_table_root_q <= reg_wdata & ROOT_MASK;
      end
      if (wr_ctl) begin
        ctl_enable_q <= reg_wdata[CTL_ENABLE_BIT];
      end
      if (wr_paddr) begin
        probe_addr_q <= reg_wdata;
      end
      if (wr_pcmd) begin
        probe_priv_q <= reg_wdata[0];
        probe_fetch_q <= reg_wdata[1];
      end
    end
  end

  // Page size bit survives reset
  always_ff @(posedge core_clk) begin
    if (wr_ctl) begin
      ctl_page_q <= reg_wdata[CTL_PAGE_BIT];
    end
  end
  // Unused positions read as zero
  assign translation_control = {ctl_enable_q, ctl_page_q, 14'h0000};

  // Per-window registers and match logic
  logic [3:0] acc_match;
  logic [3:0] probe_match;
  genvar gi;
  for (gi = 0; gi < 4; gi++) begin : g_win
    wire [7:0] wbase = win_q[gi][31:WIN_BASE_LSB];
    wire [7:0] wmask = win_q[gi][23:WIN_MASK_LSB];
    wire [1:0] wpriv = win_q[gi][WIN_PRIV_LSB +: 2];
    wire acc_priv_ok = wpriv[1] || (wpriv[0] == privilege_space_bit);
    wire prb_priv_ok = wpriv[1] || (wpriv[0] == probe_priv_q);
    always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
        win_q[gi] <= WORD_RESET;
      end else if (reg_wr && reg_addr == REG_DWIN0 + 4'(gi)) begin
        win_q[gi] <= reg_wdata & WIN_MASK;
      end
    end
    assign acc_match[gi] = win_q[gi][WIN_EN_BIT] && acc_priv_ok &&
      (((acc_addr[31:24] ^ wbase) & ~wmask) == 8'h00);
    assign probe_match[gi] = win_q[gi][WIN_EN_BIT] && prb_priv_ok &&
      (((probe_addr_q[31:24] ^ wbase) & ~wmask) == 8'h00);
  end

  // Windows 0,1 data; 2,3 instruction; lower index wins
  wire [1:0] acc_sel = acc_fetch ? acc_match[3:2] : acc_match[1:0];
  wire [1:0] prb_sel = probe_fetch_q ? probe_match[3:2] : probe_match[1:0];
  wire [1:0] acc_idx = {acc_fetch, ~acc_sel[0]};
  wire acc_win = |acc_sel;
  wire prb_win = |prb_sel;
  wire [31:0] hit_win = win_q[acc_idx];

  wire paging_on = ctl_enable_q && !inh_q;
  wire use_pages = paging_on && !acc_win;

  wire [1:0] nxt_cm = acc_win ? hit_win[WIN_CM_LSB +: 2] :
    (use_pages ? page_cache_mode : CM_WRITE_THROUGH);
  wire nxt_wp = acc_win ? hit_win[WIN_WP_BIT] : (use_pages && page_wp);
  wire [1:0] nxt_attr = acc_win ?
    {hit_win[WIN_U1_BIT], hit_win[WIN_U0_BIT]} :
    (use_pages ? page_attr : 2'h0);
  wire [31:0] nxt_phys = use_pages ? page_phys : acc_addr;
  wire acc_ready = !use_pages || page_hit;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_done <= 1'b0;
      phys_addr <= WORD_RESET;
      cache_mode <= CM_WRITE_THROUGH;
      acc_abort <= 1'b0;
      page_attr_out_0 <= 1'b0;
      page_attr_out_1 <= 1'b0;
      translate_req <= 1'b0;
      table_root <= WORD_RESET;
      page_8k <= 1'b0;
    end else begin
      acc_done <= acc_valid && acc_ready;
      phys_addr <= nxt_phys;
      cache_mode <= nxt_cm;
      acc_abort <= acc_valid && acc_ready && acc_write && nxt_wp;
      page_attr_out_0 <= acc_valid && acc_ext && nxt_attr[0];
      page_attr_out_1 <= acc_valid && acc_ext && nxt_attr[1];
      translate_req <= acc_valid && use_pages && !page_hit;
      table_root <= (probe_start ? probe_priv_q : privilege_space_bit) ?
        supervisor_table_root_q : user_table_root_q;
      page_8k <= ctl_page_q;
    end
  end

  // Probe: a window hit answers the cycle after the command; the walker is started either way
  wire [31:0] walk_result = probe_bus_err ? (32'h1 << PR_BUS_ERR) :
    {probe_phys, 1'b0, probe_global, probe_attr, probe_super, probe_cm,
     probe_mod, 1'b0, probe_wp_any, 1'b0, probe_valid};

  // Command's privilege/fetch take effect next cycle, so test window then
  logic probe_pend_q;
  logic probe_start_seen_q;
  wire prb_done_win = probe_pend_q && prb_win;

  // Walker always starts; its answer is dropped after a window hit
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      probe_result_q <= WORD_RESET;
      probe_start <= 1'b0;
      probe_addr <= WORD_RESET;
    end else begin
      probe_start <= wr_pcmd;
      probe_addr <= probe_addr_q;
      if (prb_done_win) begin
        probe_result_q <= (32'h1 << PR_HIT) | (32'h1 << PR_RES);
      end else if (probe_done && probe_start_seen_q) begin
        probe_result_q <= walk_result;
      end else if (wr_probe) begin
        probe_result_q <= reg_wdata;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      probe_pend_q <= 1'b0;
      probe_start_seen_q <= 1'b0;
    end else begin
      probe_pend_q <= wr_pcmd;
      if (probe_pend_q && !prb_win) begin
        probe_start_seen_q <= 1'b1;
      end else if (probe_done) begin
        probe_start_seen_q <= 1'b0;
      end
    end
  end

  wire [31:0] rd_mux =
    (reg_addr == REG_USER_ROOT) ? user_table_root_q :
    (reg_addr == REG_SUPER_ROOT) ? supervisor_table_root_q :
    (reg_addr == REG_CONTROL) ? {16'h0000, translation_control} :
    (reg_addr >= REG_DWIN0 && reg_addr <= REG_IWIN1) ?
      win_q[2'(reg_addr - REG_DWIN0)] :
    (reg_addr == REG_PROBE) ? probe_result_q :
    (reg_addr == REG_PROBE_ADDR) ? probe_addr_q :
    (reg_addr == REG_PROBE_CMD) ? {30'h0, probe_fetch_q, probe_priv_q} :
    32'h00000000;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= WORD_RESET;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : WORD_RESET;
    end
  end

  property p_ctl_reserved;
    @(posedge core_clk) disable iff (!rst_n)
    reg_rd && reg_addr == REG_CONTROL |=> reg_rdata[13:0] == 14'h0000;
  endproperty
  a_ctl_reserved: assert property (p_ctl_reserved)
    else $error("control reserved bits not zero");

  property p_win_reserved;
    @(posedge core_clk) disable iff (!rst_n)
    reg_rd && reg_addr >= REG_DWIN0 && reg_addr <= REG_IWIN1 |=>
      (reg_rdata & ~WIN_MASK) == 32'h0;
  endproperty
  a_win_reserved: assert property (p_win_reserved)
    else $error("window reserved bits not zero");

  property p_passthru;
    @(posedge core_clk) disable iff (!rst_n)
    !paging_on |=> phys_addr == $past(acc_addr);
  endproperty
  a_passthru: assert property (p_passthru)
    else $error("address changed with paging off");

  property p_default_attr;
    @(posedge core_clk) disable iff (!rst_n)
    acc_valid && !paging_on && !acc_win |=>
      cache_mode == CM_WRITE_THROUGH && !acc_abort &&
      !page_attr_out_0 && !page_attr_out_1;
  endproperty
  a_default_attr: assert property (p_default_attr)
    else $error("default attributes wrong");

  property p_wp_abort;
    @(posedge core_clk) disable iff (!rst_n)
    acc_valid && acc_win && acc_write && hit_win[WIN_WP_BIT] |=> acc_abort;
  endproperty
  a_wp_abort: assert property (p_wp_abort)
    else $error("protected write not aborted");

  property p_win_cm;
    @(posedge core_clk) disable iff (!rst_n)
    acc_win |=> cache_mode == $past(hit_win[WIN_CM_LSB +: 2]);
  endproperty
  a_win_cm: assert property (p_win_cm)
    else $error("window cache mode not applied");

  property p_root_sel;
    @(posedge core_clk) disable iff (!rst_n)
    !probe_start && privilege_space_bit |=>
      table_root == $past(supervisor_table_root_q);
  endproperty
  a_root_sel: assert property (p_root_sel)
    else $error("wrong root for supervisor");

  sequence s_win_probe;
    wr_pcmd ##1 prb_win;
  endsequence
  property p_probe_hit;
    @(posedge core_clk) disable iff (!rst_n)
    s_win_probe |=> probe_result_q == 32'h00000003;
  endproperty
  a_probe_hit: assert property (p_probe_hit)
    else $error("window probe result wrong");

  property p_bus_err;
    @(posedge core_clk) disable iff (!rst_n)
    probe_done && probe_start_seen_q && probe_bus_err && !prb_done_win |=>
      probe_result_q == 32'h00000800;
  endproperty
  a_bus_err: assert property (p_bus_err)
    else $error("bus error result wrong");

  property p_page_size;
    @(posedge core_clk) disable iff (!rst_n)
    wr_ctl |=> ##1 page_8k == $past(reg_wdata[CTL_PAGE_BIT], 2);
  endproperty
  a_page_size: assert property (p_page_size)
    else $error("page size output wrong");

  property p_ext_attr;
    @(posedge core_clk) disable iff (!rst_n)
    !acc_ext |=> !page_attr_out_0 && !page_attr_out_1;
  endproperty
  a_ext_attr: assert property (p_ext_attr)
    else $error("attribute outputs without bus transfer");

  property p_inhibit;
    @(posedge core_clk) disable iff (!rst_n)
    inh_q && !acc_win |=> phys_addr == $past(acc_addr) && !translate_req;
  endproperty
  a_inhibit: assert property (p_inhibit)
    else $error("paging not suppressed by inhibit");

  property p_miss_req;
    @(posedge core_clk) disable iff (!rst_n)
    acc_valid && paging_on && !acc_win && !page_hit |=>
      translate_req && !acc_done;
  endproperty
  a_miss_req: assert property (p_miss_req)
    else $error("page miss not requested");

  property p_walk_res;
    @(posedge core_clk) disable iff (!rst_n)
    probe_done && probe_start_seen_q && !probe_bus_err && !prb_done_win |=>
      probe_result_q[PR_RES] == $past(probe_valid);
  endproperty
  a_walk_res: assert property (p_walk_res)
    else $error("resident flag wrong after walk");
endmodule

// >>> verification/mtc_walker_model.sv
// Table-walk partner that answers probe requests after a fixed delay
`timescale 1ns/100ps
module mtc_walker_model
  import mtc_pkg::*;
#(
  parameter int DLY = 4
)
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic probe_start,
  input wire logic [31:0] probe_addr,
  input wire logic fail_walk,
  output logic probe_done,
  output logic probe_bus_err,
  output logic probe_valid,
  output logic [19:0] probe_phys,
  output logic probe_global,
  output logic [1:0] probe_attr,
  output logic probe_super,
  output logic [1:0] probe_cm,
  output logic probe_mod,
  output logic probe_wp_any
);
  logic busy_q;
  logic junk_q;
  logic [3:0] cnt_q;
  logic [31:0] addr_q;
  logic fin;
  assign fin = busy_q && (cnt_q == DLY[3:0]);
  assign probe_done = fin;
  // Result lines toggle outside the done cycle so stale values never match
  assign probe_bus_err = fin ? fail_walk : junk_q;
  assign probe_valid = fin ? !fail_walk : junk_q;
  assign probe_phys = fin ? addr_q[31:12] : {20{junk_q}};
  assign probe_global = fin ? 1'b1 : junk_q;
  assign probe_attr = fin ? 2'h2 : {2{junk_q}};
  assign probe_super = fin ? 1'b0 : junk_q;
  assign probe_cm = fin ? 2'h1 : {2{junk_q}};
  assign probe_mod = fin ? 1'b1 : junk_q;
  assign probe_wp_any = fin ? 1'b1 : junk_q;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_q <= 1'b0;
      junk_q <= 1'b0;
      cnt_q <= 4'h0;
      addr_q <= 32'h00000000;
    end else begin
      junk_q <= !junk_q;
      if (probe_start) begin
        busy_q <= 1'b1;
        cnt_q <= 4'h0;
        addr_q <= probe_addr;
      end else if (fin) begin
        busy_q <= 1'b0;
      end else if (busy_q) begin
        cnt_q <= cnt_q + 4'h1;
      end
    end
  end
endmodule

// >>> verification/mtc_regs_tb.sv
// Self-checking bench for the translation control registers
`timescale 1ns/100ps
module mtc_regs_tb
  import mtc_pkg::*;
;
  logic core_clk, rst_n, reg_wr, reg_rd, inhib, fail_walk, acc_valid;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, acc_addr, phys_addr, page_phys;
  logic [31:0] table_root, probe_addr;
  logic priv, fetch, wr, ext, page_hit, page_wp, acc_done, acc_abort;
  logic attr0, attr1, translate_req, page_8k, probe_start, probe_done;
  logic probe_bus_err, probe_valid, probe_global, probe_super, probe_mod;
  logic probe_wp_any;
  logic [1:0] page_cm, page_attr, cache_mode, probe_attr, probe_cm;
  logic [19:0] probe_phys;
  int mismatches, compares;

  mtc_regs i_mtc_regs (.core_clk(core_clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .translation_inhibit_pin(inhib), .acc_valid(acc_valid),
    .acc_addr(acc_addr), .privilege_space_bit(priv), .acc_fetch(fetch),
    .acc_write(wr), .acc_ext(ext), .page_hit(page_hit),
    .page_phys(page_phys), .page_cache_mode(page_cm), .page_attr(page_attr),
    .page_wp(page_wp), .acc_done(acc_done), .phys_addr(phys_addr),
    .cache_mode(cache_mode), .acc_abort(acc_abort),
    .page_attr_out_0(attr0), .page_attr_out_1(attr1),
    .translate_req(translate_req), .table_root(table_root),
    .page_8k(page_8k), .probe_start(probe_start), .probe_addr(probe_addr),
    .probe_done(probe_done), .probe_bus_err(probe_bus_err),
    .probe_valid(probe_valid), .probe_phys(probe_phys),
    .probe_global(probe_global), .probe_attr(probe_attr),
    .probe_super(probe_super), .probe_cm(probe_cm), .probe_mod(probe_mod),
    .probe_wp_any(probe_wp_any));

  mtc_walker_model i_mtc_walker_model (.core_clk(core_clk), .rst_n(rst_n),
    .probe_start(probe_start), .probe_addr(probe_addr),
    .fail_walk(fail_walk), .probe_done(probe_done),
    .probe_bus_err(probe_bus_err), .probe_valid(probe_valid),
    .probe_phys(probe_phys), .probe_global(probe_global),
    .probe_attr(probe_attr), .probe_super(probe_super),
    .probe_cm(probe_cm), .probe_mod(probe_mod),
    .probe_wp_any(probe_wp_any));

  task automatic final_report;
    if (mismatches == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wreg(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rreg(input logic [3:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask

  // Status packs {translate_req, done, abort, cache mode, attr1, attr0}
  task automatic access(input logic [31:0] a, input logic p, f, w,
      input logic [31:0] st, ph);
    @(posedge core_clk);
    acc_valid <= 1'b1;
    acc_addr <= a;
    priv <= p;
    fetch <= f;
    wr <= w;
    @(posedge core_clk);
    acc_valid <= 1'b0;
    #1;
    if (st[5]) begin
      chk({25'h0, translate_req, acc_done, acc_abort, cache_mode, attr1,
        attr0}, st);
      chk(phys_addr, ph);
    end else
      chk({30'h0, translate_req, acc_done}, 32'h2);
  endtask

  task automatic probe(input logic [31:0] a, input logic [31:0] exp);
    wreg(REG_PROBE_ADDR, a);
    wreg(REG_PROBE_CMD, 32'h0);
    for (int i = 0; i < 20 && !probe_done; i++)
      @(posedge core_clk);
    repeat (3) @(posedge core_clk);
    rreg(REG_PROBE, exp);
  endtask

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  initial begin
    #(8 * 5000);
    mismatches++;
    final_report;
  end

  initial begin
    {rst_n, reg_wr, reg_rd, inhib, fail_walk, acc_valid} <= '0;
    {priv, fetch, wr, page_hit, page_wp} <= '0;
    {reg_addr, reg_wdata, acc_addr} <= '0;
    ext <= 1'b1;
    page_phys <= 32'h77777000;
    page_cm <= CM_COPYBACK;
    page_attr <= 2'h3;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    wreg(REG_CONTROL, 32'h0000C000);
    @(posedge core_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    rreg(REG_CONTROL, 32'h00004000);
    chk({31'h0, page_8k}, 32'h1);
    wreg(REG_USER_ROOT, 32'h12345600);
    wreg(REG_SUPER_ROOT, 32'hABCDE000);
    rreg(REG_USER_ROOT, 32'h12345600);
    rreg(REG_SUPER_ROOT, 32'hABCDE000);
    access(32'h12345678, 1'b1, 1'b0, 1'b1, 32'h20, 32'h12345678);
    chk(table_root, 32'hABCDE000);
    access(32'h12345678, 1'b0, 1'b0, 1'b0, 32'h20, 32'h12345678);
    chk(table_root, 32'h12345600);
    wreg(REG_DWIN0, 32'h4001DEDF);
    rreg(REG_DWIN0, 32'h4001C244);
    wreg(REG_CONTROL, 32'h00008000);
    rreg(REG_CONTROL, 32'h00008000);
    access(32'h41ABC000, 1'b0, 1'b0, 1'b1, 32'h3A, 32'h41ABC000);
    access(32'h40000010, 1'b1, 1'b0, 1'b0, 32'h2A, 32'h40000010);
    access(32'h42000000, 1'b0, 1'b0, 1'b0, 32'h0, 32'h0);
    @(posedge core_clk);
    page_hit <= 1'b1;
    access(32'h42000000, 1'b0, 1'b0, 1'b1, 32'h27, 32'h77777000);
    access(32'h41000000, 1'b0, 1'b1, 1'b1, 32'h27, 32'h77777000);
    wreg(REG_DWIN0, 32'h40018244);
    access(32'h41000000, 1'b1, 1'b0, 1'b0, 32'h27, 32'h77777000);
    access(32'h41000000, 1'b0, 1'b0, 1'b0, 32'h2A, 32'h41000000);
    wreg(REG_DWIN0, 32'h4001A244);
    access(32'h41000000, 1'b0, 1'b0, 1'b0, 32'h27, 32'h77777000);
    access(32'h41000000, 1'b1, 1'b0, 1'b0, 32'h2A, 32'h41000000);
    wreg(REG_IWIN0, 32'h8000C120);
    access(32'h80001000, 1'b0, 1'b1, 1'b1, 32'h25, 32'h80001000);
    @(posedge core_clk);
    ext <= 1'b0;
    access(32'h80001000, 1'b0, 1'b1, 1'b1, 32'h24, 32'h80001000);
    @(posedge core_clk);
    ext <= 1'b1;
    wreg(REG_IWIN0, 32'h80004120);
    access(32'h80001000, 1'b0, 1'b1, 1'b1, 32'h27, 32'h77777000);
    @(posedge core_clk);
    inhib <= 1'b1;
    repeat (6) @(posedge core_clk);
    access(32'h42000000, 1'b0, 1'b0, 1'b1, 32'h20, 32'h42000000);
    access(32'h41000000, 1'b1, 1'b0, 1'b1, 32'h3A, 32'h41000000);
    @(posedge core_clk);
    inhib <= 1'b0;
    repeat (6) @(posedge core_clk);
    wreg(REG_DWIN0, 32'h4001C244);
    probe(32'h41000000, 32'h00000003);
    probe(32'h42000000, 32'h42000635);
    @(posedge core_clk);
    fail_walk <= 1'b1;
    probe(32'h42000000, 32'h00000800);
    final_report;
  end
endmodule
